/* File: rtl/opt_pkg.sv */
package opt_pkg;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PSC_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef struct packed {
      logic [CNT_W-1:0] master_reload_value;
      logic [CNT_W-1:0] slave_reload_value;
      logic [1:0] edge_select;
      logic clock_select_b;
      logic slave_output_mode_bit;
      logic slave_output_level_bit;
   } opt_cfg_t;

   typedef struct packed {
      logic master_start_trigger_bit;
      logic slave_start_trigger_bit;
      logic master_stop_trigger_bit;
      logic slave_stop_trigger_bit;
      logic out_write;
      logic out_value;
   } opt_ctl_t;

   typedef enum logic [1:0] {
      OPT_IDLE,
      OPT_WAIT,
      OPT_RUN
   } opt_state_t;
endpackage

/* File: rtl/opt_one_shot.sv */
`timescale 1ns/10ps
// Behaviour
// - Delay equals master reload plus two counts.
// - Pulse lasts slave reload count periods.
// - Master loads reload on trigger, decrements.
// - Master zero raises event, halts until trigger.
// - Slave starts on master event, counts down.
// - Slave zero raises event, halts until restart.
// - Output active after master event, inactive zero.
// - Software start bit also triggers master.
// - Master even channel, slave next higher.
// - Unit disable stops clock, ignores writes.
// - Prescaler sets two shared count clock rates.
// - Stopped channel keeps written output level.
// - Start and stop bits are self-clearing.
// - Start sets enable flags, master awaits edge.
// - Stop clears flags, freezes counters, holds output.
// - Unit disable resets channels and dividers, not the pin synchronizer, output to zero.
module opt_one_shot
   import opt_pkg::*;
#(
   parameter int unsigned MASTER_CHANNEL = 0
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Unit control
   input wire logic unit_clock_enable_bit_i,
   input wire logic [opt_pkg::PSC_W-1:0] prescaler_a_i,
   input wire logic [opt_pkg::PSC_W-1:0] prescaler_b_i,
   input wire opt_pkg::opt_cfg_t cfg_i,
   input wire opt_pkg::opt_ctl_t ctl_i,
   // Pins
   input wire logic master_trigger_input_i,
   output logic slave_pulse_output_o,
   output logic slave_pulse_output_port_mode_o,
   // Status
   output logic master_enable_status_o,
   output logic slave_enable_status_o,
   output logic master_terminal_event_o,
   output logic slave_terminal_event_o,
   output logic [opt_pkg::CNT_W-1:0] master_down_counter_o,
   output logic [opt_pkg::CNT_W-1:0] slave_down_counter_o
);
   import opt_pkg::*;

   localparam int unsigned SLAVE_CHANNEL = MASTER_CHANNEL + 1;

   logic en;
   logic [PSC_W-1:0] div_a_q;
   logic [PSC_W-1:0] div_b_q;
   logic tick_a, tick_b, tick;
   logic trig_s1_q, trig_s2_q, trig_s3_q;
   logic pin_rise;
   logic pin_fall;
   logic pin_edge;
   opt_state_t m_state_q;
   opt_state_t s_state_q;
   logic m_en_q;
   logic s_en_q;
   logic [CNT_W-1:0] m_cnt_q;
   logic [CNT_W-1:0] s_cnt_q;
   logic m_evt_q;
   logic s_evt_q;
   logic m_evt_pend_q;
   logic out_q;
   logic port_mode_q;
   logic start;
   logic stop;
   logic m_trig;
   logic m_zero, s_zero;

   // Writes are ignored while the unit is off
   assign en = unit_clock_enable_bit_i;
   assign start = en & ctl_i.master_start_trigger_bit & ctl_i.slave_start_trigger_bit;
   assign stop = en & (ctl_i.master_stop_trigger_bit | ctl_i.slave_stop_trigger_bit);

   // Two shared count clocks; divide ratio is prescaler value plus one
   assign tick_a = en & (div_a_q == prescaler_a_i);
   assign tick_b = en & (div_b_q == prescaler_b_i);
   assign tick = cfg_i.clock_select_b ? tick_b : tick_a;

   // Edge detect only on the second stage onward
   assign pin_rise = trig_s2_q & ~trig_s3_q;
   assign pin_fall = ~trig_s2_q & trig_s3_q;
   assign pin_edge = (cfg_i.edge_select == EDGE_RISE & pin_rise)
      | (cfg_i.edge_select == EDGE_FALL & pin_fall)
      | (cfg_i.edge_select == EDGE_BOTH & (pin_rise | pin_fall));
   // Edge is caught between ticks and applied on the next tick
   logic trig_pend_q;
   assign m_trig = m_en_q & (m_state_q == OPT_WAIT) & trig_pend_q & tick;
   assign m_zero = (m_cnt_q == CNT_ZERO);
   assign s_zero = (s_cnt_q == CNT_ZERO);

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         div_a_q <= '0;
         div_b_q <= '0;
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
      end
      else
      begin
         div_a_q <= tick_a || !en ? '0 : div_a_q + 1'b1;
         div_b_q <= tick_b || !en ? '0 : div_b_q + 1'b1;
         trig_s1_q <= master_trigger_input_i;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end

   // Master channel: load on trigger, count down, event and halt at zero
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         m_state_q <= OPT_IDLE;
         m_en_q <= 1'b0;
         m_cnt_q <= CNT_ZERO;
         m_evt_q <= 1'b0;
         trig_pend_q <= 1'b0;
      end
      else if (!en)
      begin
         m_state_q <= OPT_IDLE;
         m_en_q <= 1'b0;
         m_cnt_q <= CNT_ZERO;
         m_evt_q <= 1'b0;
         trig_pend_q <= 1'b0;
      end
      else
      begin
         m_evt_q <= 1'b0;
         if (stop)
         begin
            m_en_q <= 1'b0;
            m_state_q <= OPT_IDLE;
            trig_pend_q <= 1'b0;
         end
         else if (start)
         begin
            m_en_q <= 1'b1;
            m_state_q <= OPT_WAIT;
            trig_pend_q <= 1'b0;
         end
         else
         begin
            // Software start is held pending like a pin edge
            if (m_en_q && m_state_q == OPT_WAIT && (pin_edge || ctl_i.master_start_trigger_bit))
            begin
               trig_pend_q <= 1'b1;
            end
            unique case (m_state_q)
               OPT_IDLE: ;
               OPT_WAIT:
               begin
                  if (m_trig)
                  begin
                     m_cnt_q <= cfg_i.master_reload_value;
                     m_evt_q <= cfg_i.master_reload_value == CNT_ZERO;
                     m_state_q <= cfg_i.master_reload_value == CNT_ZERO ? OPT_WAIT : OPT_RUN;
                     trig_pend_q <= 1'b0;
                  end
               end
               OPT_RUN:
               begin
                  if (tick)
                  begin
                     if (m_cnt_q == CNT_ONE || m_zero)
                     begin
                        m_cnt_q <= CNT_ZERO;
                        m_evt_q <= 1'b1;
                        m_state_q <= OPT_WAIT;
                     end
                     else
                     begin
                        m_cnt_q <= m_cnt_q - CNT_ONE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Slave channel: master event starts it; output follows count window
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_state_q <= OPT_IDLE;
         s_en_q <= 1'b0;
         s_cnt_q <= CNT_ZERO;
         s_evt_q <= 1'b0;
         m_evt_pend_q <= 1'b0;
         out_q <= 1'b0;
         port_mode_q <= 1'b1;
      end
      else if (!en)
      begin
         s_state_q <= OPT_IDLE;
         s_en_q <= 1'b0;
         s_cnt_q <= CNT_ZERO;
         s_evt_q <= 1'b0;
         m_evt_pend_q <= 1'b0;
         out_q <= 1'b0;
         port_mode_q <= 1'b1;
      end
      else
      begin
         s_evt_q <= 1'b0;
         port_mode_q <= 1'b0;
         // Output bit writes allowed only while stopped; hold otherwise
         if (ctl_i.out_write && !s_en_q)
         begin
            out_q <= ctl_i.out_value;
         end
         if (stop)
         begin
            s_en_q <= 1'b0;
            s_state_q <= OPT_IDLE;
            m_evt_pend_q <= 1'b0;
         end
         else if (start)
         begin
            s_en_q <= 1'b1;
            s_state_q <= OPT_WAIT;
            m_evt_pend_q <= 1'b0;
         end
         else
         begin
            if (m_evt_q && s_en_q)
            begin
               m_evt_pend_q <= 1'b1;
            end
            unique case (s_state_q)
               OPT_IDLE: ;
               OPT_WAIT:
               begin
                  // Load one count clock after the master event
                  if ((m_evt_q || m_evt_pend_q) && tick)
                  begin
                     s_cnt_q <= cfg_i.slave_reload_value;
                     s_state_q <= OPT_RUN;
                     m_evt_pend_q <= 1'b0;
                     if (cfg_i.slave_output_mode_bit)
                     begin
                        out_q <= ~cfg_i.slave_output_level_bit;
                     end
                  end
               end
               OPT_RUN:
               begin
                  if (tick)
                  begin
                     if (s_cnt_q == CNT_ONE || s_zero)
                     begin
                        s_cnt_q <= CNT_ZERO;
                        s_evt_q <= 1'b1;
                        s_state_q <= OPT_WAIT;
                        if (cfg_i.slave_output_mode_bit)
                        begin
                           out_q <= cfg_i.slave_output_level_bit;
                        end
                     end
                     else
                     begin
                        s_cnt_q <= s_cnt_q - CNT_ONE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Level bit set means active low; output pin is the out register
   assign slave_pulse_output_o = out_q;
   assign slave_pulse_output_port_mode_o = port_mode_q;
   assign master_enable_status_o = m_en_q;
   assign slave_enable_status_o = s_en_q;
   assign master_terminal_event_o = m_evt_q;
   assign slave_terminal_event_o = s_evt_q;
   assign master_down_counter_o = m_cnt_q;
   assign slave_down_counter_o = s_cnt_q;
endmodule // opt_one_shot

/* File: test/opt_one_shot_monitor.sv */
`timescale 1ns/10ps
module opt_one_shot_chk
   import opt_pkg::*;
(
   // Watched ports
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic unit_clock_enable_bit_i,
   input wire logic [opt_pkg::PSC_W-1:0] prescaler_a_i,
   input wire opt_pkg::opt_cfg_t cfg_i,
   input wire opt_pkg::opt_ctl_t ctl_i,
   input wire logic slave_pulse_output_o,
   input wire logic slave_pulse_output_port_mode_o,
   input wire logic master_enable_status_o,
   input wire logic slave_enable_status_o,
   input wire logic master_terminal_event_o,
   input wire logic [opt_pkg::CNT_W-1:0] master_down_counter_o
);
   wire u = unit_clock_enable_bit_i;
   wire ev = master_terminal_event_o;
   wire en = master_enable_status_o || slave_enable_status_o;
   wire act = slave_pulse_output_o == ~cfg_i.slave_output_level_bit;
   // Cycle figures hold only while one count clock is one clk
   wire fast = prescaler_a_i == 4'h0 && !cfg_i.clock_select_b;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_rise;
      fast && slave_enable_status_o && !act ##1 act;
   endsequence
   property p_ev_out;
      ev && fast && u |=> act;
   endproperty
   a_ev_out: assert property (p_ev_out) else $error("no pulse");
   property p_rise;
      s_rise |-> $past(ev);
   endproperty
   a_rise: assert property (p_rise) else $error("early pulse");
   property p_zero;
      ev |-> master_down_counter_o == CNT_ZERO;
   endproperty
   a_zero: assert property (p_zero) else $error("event off zero");
   property p_off;
      !u |=> slave_pulse_output_port_mode_o && !slave_pulse_output_o && !en;
   endproperty
   a_off: assert property (p_off) else $error("unit off");
   property p_start;
      u && ctl_i[5:2] == 4'hc |=> master_enable_status_o && slave_enable_status_o;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_stop;
      u && ctl_i[3:2] != 2'h0 |=> !en;
   endproperty
   a_stop: assert property (p_stop) else $error("no stop");
   property p_freeze;
      u && !en |=> $stable(master_down_counter_o);
   endproperty
   a_freeze: assert property (p_freeze) else $error("counter moved");
   property p_hold;
      u && !slave_enable_status_o && !ctl_i.out_write |=> $stable(slave_pulse_output_o);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved");
endmodule // opt_one_shot_chk
bind opt_one_shot opt_one_shot_chk opt_one_shot_chk_i (.clk_i, .resetn_i,
   .unit_clock_enable_bit_i, .prescaler_a_i, .cfg_i, .ctl_i, .slave_pulse_output_o,
   .slave_pulse_output_port_mode_o, .master_enable_status_o, .slave_enable_status_o,
   .master_terminal_event_o, .master_down_counter_o);

/* File: test/opt_pin_model.sv */
`timescale 1ns/10ps
module opt_pin_model
(
   // Request and pin
   input wire logic clk_i,
   input wire logic fire_i,
   output logic pin_o = 1'b0
);
   int hold = 0;
   // Long enough that the falling edge comes after the first pulse is over
   always @(posedge clk_i)
   begin
      hold = fire_i ? 40 : (hold > 0 ? hold - 1 : 0);
      // Nonblocking so the block samples the old level at this edge
      pin_o <= hold > 0;
   end
endmodule // opt_pin_model

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import opt_pkg::*;
   logic clk_i = 0;
   logic resetn_i = 0;
   logic unit_clock_enable_bit_i = 0;
   logic fire = 0;
   logic [PSC_W-1:0] prescaler_a_i = 4'h0;
   logic [PSC_W-1:0] prescaler_b_i = 4'h3;
   opt_cfg_t cfg_i = '0;
   opt_ctl_t ctl_i = '0;
   logic master_trigger_input_i, slave_pulse_output_o, slave_pulse_output_port_mode_o, last;
   logic master_enable_status_o, slave_enable_status_o, master_terminal_event_o;
   logic slave_terminal_event_o;
   logic [CNT_W-1:0] master_down_counter_o, slave_down_counter_o, frozen;
   int n_mismatch = 0, check_count = 0, cyc = 0, seed = 15, t_trig = 0, t_ev = 0, t_rise = 0;
   int q_dly[$], q_wid[$];
   int per = 1;
   opt_one_shot opt_one_shot_i (.clk_i, .resetn_i, .unit_clock_enable_bit_i, .prescaler_a_i,
      .prescaler_b_i, .cfg_i, .ctl_i, .master_trigger_input_i, .slave_pulse_output_o,
      .slave_pulse_output_port_mode_o, .master_enable_status_o, .slave_enable_status_o,
      .master_terminal_event_o, .slave_terminal_event_o, .master_down_counter_o,
      .slave_down_counter_o);
   opt_pin_model opt_pin_model_i (.clk_i, .fire_i(fire), .pin_o(master_trigger_input_i));
   initial forever #2.5 clk_i = ~clk_i;
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Control bits are one-clock strobes: start, start, stop, stop, write, value
   task automatic pulse_ctl(opt_ctl_t c);
      ctl_i = c;
      tick(1);
      ctl_i = '0;
      tick(2);
   endtask
   task automatic shot(bit sw);
      logic [15:0] m, s;
      int n;
      m = 16'({$random(seed)} % 6 + 1);
      s = 16'({$random(seed)} % 5 + 1);
      cfg_i.master_reload_value = m;
      cfg_i.slave_reload_value = s;
      // A pin shot gives one pulse per selected edge of the long pin pulse
      n = sw ? 1 : (cfg_i.edge_select == EDGE_BOTH ? 2 : int'(cfg_i.edge_select != EDGE_NONE));
      repeat (n)
      begin
         // Trigger to tick jitter hides the delay under a slow count clock
         q_dly.push_back(sw && per == 1 ? m + 2 : -1);
         q_wid.push_back(s * per);
      end
      t_trig = cyc + 1;
      if (sw)
         pulse_ctl(6'h20);
      fire = !sw;
      tick(1);
      fire = 0;
      tick(m + s + 60);
   endtask
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   // Result watcher: one note per pulse edge, oldest first
   always @(negedge clk_i)
   begin
      if (master_terminal_event_o === 1'b1)
         t_ev = cyc;
      if (slave_enable_status_o === 1'b1 && slave_pulse_output_o !== last)
      begin
         if (q_wid.size() == 0)
            chk("spurious", slave_pulse_output_o, 0);
         else if (last === 1'b0)
         begin
            t_rise = cyc;
            chk("ev_to_out", cyc - t_ev, per);
            if (q_dly[0] >= 0)
               chk("delay", cyc - t_trig, q_dly[0]);
            void'(q_dly.pop_front());
         end
         else
         begin
            chk("width", cyc - t_rise, q_wid.pop_front());
            chk("slave_event", slave_terminal_event_o, 1);
            chk("slave_count", slave_down_counter_o, 0);
         end
      end
      last = slave_pulse_output_o;
   end
   initial
   begin
      tick(8);
      resetn_i = 1;
      tick(1);
      chk("port_mode", slave_pulse_output_port_mode_o, 1);
      unit_clock_enable_bit_i = 1;
      cfg_i.slave_output_mode_bit = 1;
      pulse_ctl(6'h03);
      tick(4);
      chk("out_hold", slave_pulse_output_o, 1);
      pulse_ctl(6'h02);
      pulse_ctl(6'h30);
      chk("enables", {master_enable_status_o, slave_enable_status_o}, 2'h3);
      $display("test start done");
      repeat (5) shot(1);
      for (int e = 0; e < 4; e++)
      begin
         cfg_i.edge_select = 2'(e);
         repeat (2) shot(0);
      end
      // Clock source changes only while stopped
      pulse_ctl(6'h0c);
      cfg_i.clock_select_b = 1'b1;
      per = prescaler_b_i + 1;
      pulse_ctl(6'h30);
      repeat (2) shot(1);
      $display("test shots done");
      cfg_i.master_reload_value = 16'h0028;
      pulse_ctl(6'h20);
      tick(8);
      pulse_ctl(6'h0c);
      frozen = master_down_counter_o;
      tick(6);
      chk("frozen", master_down_counter_o, frozen);
      chk("stopped", master_enable_status_o, 0);
      unit_clock_enable_bit_i = 0;
      pulse_ctl(6'h03);
      chk("off", {slave_pulse_output_o, slave_pulse_output_port_mode_o}, 2'h1);
      chk("leftover", q_wid.size(), 0);
      $display("test stop done");
      stop_test();
   end
endmodule // testbench
